//--- verification/iew_assertions.sv
`timescale 1ns/1ns
module iew_assertions (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // lines and levels
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_filt,
  input wire logic sda_filt,
  input wire logic scl_hold_out,
  input wire logic scl_hold_oe,
  input wire logic low_power,
  input wire logic wakeup,
  input wire logic stop_holdoff,
  input wire logic module_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire en_w = pwdata[0];
  wire ho_w = pwdata[7];
  sequence s_wr(a);
    psel && penable && pwrite && paddr == a;
  endsequence
  // two sync stages come first, so nothing reaches the filter output sooner
  a_filt_scl_delay: assert property ($changed(scl_filt) |-> $past(scl_in, 2) == scl_filt)
    else $error("scl filter passed early");
  a_filt_sda_delay: assert property ($changed(sda_filt) |-> $past(sda_in, 2) == sda_filt)
    else $error("sda filter passed early");
  a_wake_lp_clear: assert property (!low_power |=> !wakeup)
    else $error("wakeup outside low power");
  a_wake_needs_lp: assert property ($rose(wakeup) |-> $past(low_power))
    else $error("wakeup without low power");
  a_hold_pin_low: assert property (!scl_hold_out)
    else $error("hold pin value not low");
  a_hold_release: assert property ((s_wr(8'h00) or s_wr(8'h04)) |=> !scl_hold_oe)
    else $error("scl hold kept after write");
  a_enable_echo: assert property (s_wr(8'h00) |=> module_enable == $past(en_w))
    else $error("module enable mismatch");
  a_holdoff_echo: assert property (s_wr(8'h08) |=> stop_holdoff == $past(ho_w))
    else $error("stop holdoff mismatch");
endmodule

bind iew_event_irq iew_assertions u_chk (.*);

//--- verification/iew_bus_model.sv
`timescale 1ns/1ns
module iew_bus_model (
  // open-drain lines, pulled up when released
  output logic scl_in,
  output logic sda_in
);
  initial begin
    scl_in = 1'b1;
    sda_in = 1'b1;
  end
  // bus clock toggles inside a frame and during a glitch
  task frame(input int n);
    #7 sda_in = 1'b0;
    #40 scl_in = 1'b0;
    repeat (n) begin
      #40 scl_in = 1'b1;
      #40 scl_in = 1'b0;
    end
    #40 scl_in = 1'b1;
    #40 sda_in = 1'b1;
    #80;
  endtask
  task glitch(input int c);
    #3 scl_in = 1'b0;
    #(4 * c) scl_in = 1'b1;
    #40;
  endtask
endmodule

//--- verification/tb_i2c_event_irq_dma_wakeup.sv
`timescale 1ns/1ns
module tb_i2c_event_irq_dma_wakeup;
  localparam logic [7:0] C = iew_pkg::CTRL_OFS;
  localparam logic [7:0] S = iew_pkg::STAT_OFS;
  localparam logic [7:0] F = iew_pkg::FILT_OFS;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, saw_low = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, scl_in, sda_in, scl_hold_out, scl_hold_oe, scl_filt, sda_filt;
  logic irq, dma_req, wakeup, stop_holdoff, module_enable;
  logic master_active = 0, master_drives_sda = 0, tx_phase = 0, rx_ack_phase = 0, start_req = 0;
  logic rstart_req = 0, stop_req = 0, bus_busy = 0, addr_match = 0, gc_addr = 0, rx_dir_read = 0;
  logic data_byte = 0, slave_rx = 0, low_power = 0, scl_low_timeout = 0, sda_low_timeout = 0;
  logic bus_idle_timeout = 0;
  int failures = 0, num_checks = 0;
  iew_event_irq u_dut (.*);
  iew_bus_model u_bus (.*);
  always #2 pclk = ~pclk;
  always @(posedge pclk) if (scl_filt === 1'b0) saw_low <= 1'b1;
  task end_of_test;
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd & m);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl", C, 32'hffffffff, 32'h0);
    rchk("filt", F, 32'hffffffff, 32'h0);
    rchk("unmapped", 8'hfc, 32'hffffffff, 32'h0);
    apb(1'b1, C, 32'h3);
    @(posedge pclk);
    chk("mod_en", 32'h1, {31'h0, module_enable});
    master_active <= 1'b1;
    bus_busy <= 1'b1;
    start_req <= 1'b1;
    @(posedge pclk);
    start_req <= 1'b0;
    master_active <= 1'b0;
    @(posedge pclk);
    chk("irq_arbitration_lost_flag", 32'h1, {31'h0, irq});
    rchk("arbitration_lost_flag", S, 32'h84, 32'h84);
    apb(1'b1, C, 32'h1);
    @(posedge pclk);
    chk("irq_off", 32'h0, {31'h0, irq});
    apb(1'b1, C, 32'h3);
    @(posedge pclk);
    chk("irq_kept", 32'h1, {31'h0, irq});
    apb(1'b1, S, 32'h84);
    rchk("arbitration_lost_flag_clr", S, 32'h84, 32'h0);
    rstart_req <= 1'b1;
    @(posedge pclk);
    rstart_req <= 1'b0;
    rchk("arbitration_lost_flag_rs", S, 32'h84, 32'h84);
    apb(1'b1, S, 32'h84);
    apb(1'b1, C, 32'h43);
    scl_low_timeout <= 1'b1;
    @(posedge pclk);
    scl_low_timeout <= 1'b0;
    @(posedge pclk);
    chk("irq_scl_low_timeout_flag", 32'h1, {31'h0, irq});
    apb(1'b1, S, 32'h10);
    @(posedge pclk);
    chk("scl_low_timeout_flag_clr", 32'h0, {31'h0, irq});
    sda_low_timeout <= 1'b1;
    @(posedge pclk);
    sda_low_timeout <= 1'b0;
    @(posedge pclk);
    chk("irq_sdal", 32'h0, {31'h0, irq});
    apb(1'b1, C, 32'h0b);
    @(posedge pclk);
    chk("irq_sdal_en", 32'h1, {31'h0, irq});
    apb(1'b1, S, 32'hdf);
    apb(1'b1, C, 32'h07);
    u_bus.frame(9);
    rchk("tcf9", S, 32'h89, 32'h89);
    apb(1'b1, S, 32'h81);
    @(posedge pclk);
    chk("irq_stop", 32'h1, {31'h0, irq});
    apb(1'b1, S, 32'h08);
    @(posedge pclk);
    chk("irq_none", 32'h0, {31'h0, irq});
    u_bus.frame(8);
    rchk("tcf8", S, 32'h1, 32'h0);
    apb(1'b1, C, 32'h17);
    data_byte <= 1'b1;
    u_bus.frame(8);
    chk("hold", 32'h1, {31'h0, scl_hold_oe});
    rchk("tcf8_fast", S, 32'h1, 32'h1);
    apb(1'b1, C, 32'h47);
    @(posedge pclk);
    chk("hold_rel", 32'h0, {31'h0, scl_hold_oe});
    chk("dma_req", 32'h1, {31'h0, dma_req});
    chk("irq_dma", 32'h0, {31'h0, irq});
    apb(1'b1, C, 32'h07);
    apb(1'b1, S, 32'hdf);
    @(posedge pclk);
    chk("dma_off", 32'h0, {31'h0, dma_req});
    bus_idle_timeout <= 1'b1;
    rchk("idle", S, 32'h20, 32'h20);
    chk("irq_idle", 32'h0, {31'h0, irq});
    bus_idle_timeout <= 1'b0;
    rchk("idle_off", S, 32'h20, 32'h0);
    apb(1'b1, F, 32'h83);
    @(posedge pclk);
    chk("holdoff", 32'h1, {31'h0, stop_holdoff});
    saw_low <= 1'b0;
    u_bus.glitch(2);
    chk("glitch", 32'h0, {31'h0, saw_low});
    u_bus.glitch(8);
    chk("pulse", 32'h1, {31'h0, saw_low});
    apb(1'b1, C, 32'h183);
    low_power <= 1'b1;
    slave_rx <= 1'b1;
    rx_dir_read <= 1'b1;
    gc_addr <= 1'b1;
    @(posedge pclk);
    gc_addr <= 1'b0;
    @(posedge pclk);
    chk("wake", 32'h1, {31'h0, wakeup});
    rchk("addressed_as_slave_flag", S, 32'h102, 32'h102);
    low_power <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("wake_off", 32'h0, {31'h0, wakeup});
    end_of_test;
  end
  initial begin
    #100000;
    failures++;
    end_of_test;
  end
endmodule

//--- verilog/iew_event_irq.sv
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ns
module iew_event_irq #(
  parameter int FILT_MAX = 31
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // two-wire pins, asynchronous
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_hold_out,
  output logic scl_hold_oe,
  // events from shifter and timeout logic
  input wire logic master_active,
  input wire logic master_drives_sda,
  input wire logic tx_phase,
  input wire logic rx_ack_phase,
  input wire logic start_req,
  input wire logic rstart_req,
  input wire logic stop_req,
  input wire logic bus_busy,
  input wire logic addr_match,
  input wire logic gc_addr,
  input wire logic rx_dir_read,
  input wire logic data_byte,
  input wire logic slave_rx,
  input wire logic low_power,
  input wire logic scl_low_timeout,
  input wire logic sda_low_timeout,
  input wire logic bus_idle_timeout,
  // filtered lines and requests
  output logic scl_filt,
  output logic sda_filt,
  output logic irq,
  output logic dma_req,
  output logic wakeup,
  output logic stop_holdoff,
  output logic module_enable
);

  typedef struct packed {
    logic lvl;
    logic [iew_pkg::FILT_W-1:0] cnt;
  } iew_filt_s;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_f;
    logic sda_f;
    logic [iew_pkg::FILT_W-1:0] scl_cnt;
    logic [iew_pkg::FILT_W-1:0] sda_cnt;
    logic [3:0] bitn;
    logic [8:0] ctrl;
    logic [7:0] filt;
    logic transfer_complete_flag;
    logic addressed_as_slave_flag;
    logic arbitration_lost_flag;
    logic stop_detect_flag;
    logic scl_low_timeout_flag;
    logic sda_low_timeout_flag;
    logic module_irq_flag;
    logic slave_direction_bit;
    logic hold;
    logic wake;
    logic [31:0] rdata;
  } iew_state_s;

  iew_state_s st_r;
  iew_state_s st_nxt;

  // decoded bus strobes
  logic wr;
  logic rd;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_filt;
  // line events after the filter
  iew_filt_s scl_step;
  iew_filt_s sda_step;
  logic scl_fall;
  logic scl_rise;
  logic start_det;
  logic stop_det;
  // flag set events
  logic arb_event;
  logic match;
  logic tc_event;
  logic lp_slave;
  // request steering
  logic en_irq;
  logic dma_on;
  logic err_src;
  logic other_src;
  logic cpu_src;
  logic [31:0] stat_word;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic w1c(input logic en, input logic [31:0] d, input int b);
    w1c = en && d[b];
  endfunction

  // a new level must persist past the programmed count; zero passes at once
  function automatic iew_filt_s filt_step(input logic lvl, input logic [iew_pkg::FILT_W-1:0] cnt,
    input logic raw, input logic [iew_pkg::FILT_W-1:0] lim);
    filt_step.lvl = lvl;
    filt_step.cnt = '0;
    if (raw != lvl) begin
      if (cnt >= lim) begin
        filt_step.lvl = raw;
      end else begin
        filt_step.cnt = cnt + 1'b1;
      end
    end
  endfunction

  assign wr = psel && penable && pwrite;
  // read data is latched at the setup edge, so the access phase needs no wait
  assign rd = psel && !penable && !pwrite;
  assign wr_ctrl = wr && hit(paddr, iew_pkg::CTRL_OFS);
  assign wr_stat = wr && hit(paddr, iew_pkg::STAT_OFS);
  assign wr_filt = wr && hit(paddr, iew_pkg::FILT_OFS);
  assign lp_slave = low_power && slave_rx && st_r.ctrl[iew_pkg::CTRL_WU_EN];
  // live status image, bus idle level passes straight through
  assign stat_word = {22'h0, st_r.hold, st_r.slave_direction_bit, st_r.module_irq_flag, st_r.sda_low_timeout_flag,
    bus_idle_timeout, st_r.scl_low_timeout_flag, st_r.stop_detect_flag, st_r.arbitration_lost_flag, st_r.addressed_as_slave_flag, st_r.transfer_complete_flag};

  always_comb begin
    st_nxt = st_r;
    // two flop synchronisers; only the second stage feeds the filter
    st_nxt.scl_s = {st_r.scl_s[0], scl_in};
    st_nxt.sda_s = {st_r.sda_s[0], sda_in};
    scl_step = filt_step(st_r.scl_f, st_r.scl_cnt, st_r.scl_s[1], st_r.filt[iew_pkg::FILT_W-1:0]);
    sda_step = filt_step(st_r.sda_f, st_r.sda_cnt, st_r.sda_s[1], st_r.filt[iew_pkg::FILT_W-1:0]);
    st_nxt.scl_f = scl_step.lvl;
    st_nxt.scl_cnt = scl_step.cnt;
    st_nxt.sda_f = sda_step.lvl;
    st_nxt.sda_cnt = sda_step.cnt;

    scl_fall = st_r.scl_f && !st_nxt.scl_f;
    scl_rise = !st_r.scl_f && st_nxt.scl_f;
    start_det = st_r.scl_f && st_nxt.scl_f && st_r.sda_f && !st_nxt.sda_f;
    stop_det = st_r.scl_f && st_nxt.scl_f && !st_r.sda_f && st_nxt.sda_f;

    // the scl fall closing a start is no bit clock, so the count parks at all ones
    tc_event = 1'b0;
    if (start_det) begin
      st_nxt.bitn = '1;
    end else if (stop_det) begin
      st_nxt.bitn = '0;
    end else if (scl_fall) begin
      if (st_r.bitn == 4'hf || st_r.bitn == 4'h8) begin
        st_nxt.bitn = '0;
      end else begin
        st_nxt.bitn = st_r.bitn + 1'b1;
      end
      // ninth fall normally, eighth with fast ack
      if (st_r.ctrl[iew_pkg::CTRL_FAST_ACKNOWLEDGE_ENABLE]) begin
        tc_event = (st_r.bitn == 4'h7);
      end else begin
        tc_event = (st_r.bitn == 4'h8);
      end
    end

    // arbitration loss causes
    arb_event = 1'b0;
    if (scl_rise && master_drives_sda && !st_nxt.sda_f && (tx_phase || rx_ack_phase)) begin
      arb_event = 1'b1;
    end
    if (start_req && bus_busy) begin
      arb_event = 1'b1;
    end
    if (rstart_req && !master_active) begin
      arb_event = 1'b1;
    end
    if (stop_det && master_active && !stop_req) begin
      arb_event = 1'b1;
    end
    // address match or enabled general call
    match = addr_match || (gc_addr && st_r.ctrl[iew_pkg::CTRL_GC_EN]);

    // register writes; clears first so that hardware sets win
    if (wr_ctrl) begin
      st_nxt.ctrl = pwdata[8:0];
    end
    if (wr_filt) begin
      st_nxt.filt = pwdata[7:0];
    end
    if (w1c(wr_stat, pwdata, iew_pkg::ST_TCF)) begin
      st_nxt.transfer_complete_flag = 1'b0;
    end
    if (w1c(wr_stat, pwdata, iew_pkg::ST_ADDRESSED_AS_SLAVE_FLAG)) begin
      st_nxt.addressed_as_slave_flag = 1'b0;
    end
    if (w1c(wr_stat, pwdata, iew_pkg::ST_ARBITRATION_LOST_FLAG)) begin
      st_nxt.arbitration_lost_flag = 1'b0;
    end
    if (w1c(wr_stat, pwdata, iew_pkg::ST_STOP_DETECT_FLAG)) begin
      st_nxt.stop_detect_flag = 1'b0;
    end
    if (w1c(wr_stat, pwdata, iew_pkg::ST_SCL_LOW_TIMEOUT_FLAG)) begin
      st_nxt.scl_low_timeout_flag = 1'b0;
    end
    if (w1c(wr_stat, pwdata, iew_pkg::ST_SDA_LOW_TIMEOUT_FLAG)) begin
      st_nxt.sda_low_timeout_flag = 1'b0;
    end
    if (w1c(wr_stat, pwdata, iew_pkg::ST_MODULE_IRQ_FLAG)) begin
      st_nxt.module_irq_flag = 1'b0;
    end
    // software choosing ack releases fast-ack hold
    if (wr_ctrl || wr_stat) begin
      st_nxt.hold = 1'b0;
    end

    if (tc_event) begin
      st_nxt.transfer_complete_flag = 1'b1;
      st_nxt.module_irq_flag = 1'b1;
      // a completed byte also wakes a sleeping slave
      if (lp_slave) begin
        st_nxt.wake = 1'b1;
      end
      // hold scl on received data byte under fast ack, not after wakeup
      if (st_r.ctrl[iew_pkg::CTRL_FAST_ACKNOWLEDGE_ENABLE] && data_byte && !st_r.wake) begin
        st_nxt.hold = 1'b1;
      end
    end
    if (match) begin
      st_nxt.addressed_as_slave_flag = 1'b1;
      st_nxt.slave_direction_bit = rx_dir_read;
      st_nxt.module_irq_flag = 1'b1;
      // wakeup at end of match in slave receive while asleep
      if (lp_slave) begin
        st_nxt.wake = 1'b1;
      end
    end
    // wake drops once the core runs again
    if (!low_power) begin
      st_nxt.wake = 1'b0;
    end

    if (arb_event) begin
      st_nxt.arbitration_lost_flag = 1'b1;
      st_nxt.module_irq_flag = 1'b1;
    end
    if (stop_det) begin
      st_nxt.stop_detect_flag = 1'b1;
    end
    if (scl_low_timeout) begin
      st_nxt.scl_low_timeout_flag = 1'b1;
    end
    if (sda_low_timeout) begin
      st_nxt.sda_low_timeout_flag = 1'b1;
    end

    // read data captured in setup, zero wait state
    st_nxt.rdata = '0;
    if (rd) begin
      case (paddr)
        iew_pkg::CTRL_OFS: st_nxt.rdata = {23'h0, st_r.ctrl};
        iew_pkg::STAT_OFS: st_nxt.rdata = stat_word;
        iew_pkg::FILT_OFS: st_nxt.rdata = {24'h0, st_r.filt};
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{
        scl_s: 2'h3,
        sda_s: 2'h3,
        scl_f: 1'b1,
        sda_f: 1'b1,
        ctrl: iew_pkg::CTRL_RST,
        filt: iew_pkg::FILT_RST,
        default: '0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  assign en_irq = st_r.ctrl[iew_pkg::CTRL_IRQ_EN];
  assign dma_on = st_r.ctrl[iew_pkg::CTRL_DMA_EN];
  // arbitration loss and scl low timeout always go to cpu
  assign err_src = st_r.arbitration_lost_flag || st_r.scl_low_timeout_flag;
  // bus idle timeout never contributes
  assign other_src = (st_r.module_irq_flag && !st_r.arbitration_lost_flag) || (st_r.stop_detect_flag && st_r.ctrl[iew_pkg::CTRL_STOP_IE])
    || (st_r.sda_low_timeout_flag && st_r.ctrl[iew_pkg::CTRL_SDAL_IE]);
  // under dma only errors and wake reach the cpu
  assign cpu_src = err_src || (!dma_on && other_src) || st_r.wake;
  // level or of enabled sources, gated by irq enable
  assign irq = en_irq && cpu_src;
  // dma request from transfer complete
  assign dma_req = en_irq && dma_on && st_r.transfer_complete_flag;
  assign wakeup = en_irq && st_r.wake;
  assign scl_hold_out = 1'b0;
  assign scl_hold_oe = st_r.hold;
  assign scl_filt = st_r.scl_f;
  assign sda_filt = st_r.sda_f;
  assign stop_holdoff = st_r.filt[iew_pkg::FILT_STOP_HOLDOFF_ENABLE];
  assign module_enable = st_r.ctrl[iew_pkg::CTRL_MOD_EN];
  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

endmodule

//--- verilog/iew_pkg.sv
package iew_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] FILT_OFS = 8'h08;
  // ctrl bits
  localparam int CTRL_MOD_EN = 0;
  localparam int CTRL_IRQ_EN = 1;
  localparam int CTRL_STOP_IE = 2;
  localparam int CTRL_SDAL_IE = 3;
  localparam int CTRL_FAST_ACKNOWLEDGE_ENABLE = 4;
  localparam int CTRL_TRANSMIT_ACKNOWLEDGE_SELECT = 5;
  localparam int CTRL_DMA_EN = 6;
  localparam int CTRL_WU_EN = 7;
  localparam int CTRL_GC_EN = 8;
  // status bits
  localparam int ST_TCF = 0;
  localparam int ST_ADDRESSED_AS_SLAVE_FLAG = 1;
  localparam int ST_ARBITRATION_LOST_FLAG = 2;
  localparam int ST_STOP_DETECT_FLAG = 3;
  localparam int ST_SCL_LOW_TIMEOUT_FLAG = 4;
  localparam int ST_BUS_IDLE_TIMEOUT_FLAG = 5;
  localparam int ST_SDA_LOW_TIMEOUT_FLAG = 6;
  localparam int ST_MODULE_IRQ_FLAG = 7;
  localparam int ST_SRW = 8;
  localparam int ST_HOLD = 9;
  // filter register
  localparam int FILT_W = 5;
  localparam int FILT_STOP_HOLDOFF_ENABLE = 7;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [7:0] FILT_RST = 8'h00;
endpackage
